// [hdl/adc_output_config_regs.sv]
// output stage configuration registers of the converter
`timescale 1ns/100ps
`default_nettype none
module adc_output_config_regs
    import out_cfg_pkg::*;
#(
    parameter int SAMPLE_W = 16   // converter sample width
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // register access from serial port core
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire logic [12:0]         reg_addr,
    input  wire logic [7:0]          reg_wdata,
    output var  logic [7:0]          reg_rdata,
    // sample path
    input  wire logic [SAMPLE_W-1:0] sample_in,
    output var  logic [SAMPLE_W-1:0] sample_out,
    // output driver controls
    output var  logic                output_is_lvds,
    output var  logic                lvds_reduced_drive,
    output var  logic                outputs_disabled,
    // data output clock
    input  wire logic                data_output_clock_src,
    output var  logic                data_output_clock,
    output var  logic [4:0]          oclk_delay_code,
    output var  logic [11:0]         oclk_delay_ps,
    // clock divider input path
    input  wire logic                divider_tick_in,
    output logic                     divider_tick_out,
    // analog settings
    output var  logic [1:0]          ref_range_code,
    output var  logic                dither_enable,
    // self-test signature from built_in_self_test engine
    input  wire logic [15:0]         built_in_self_test_sig,
    // sync
    input  wire logic                sync_pin,
    output var  logic                sync_power_enable,
    output var  logic                divider_sync_pulse
);

    // refuse widths the format logic cannot serve
    if (SAMPLE_W < 2) begin : g_bad_width
        $error("SAMPLE_W must be at least 2");
    end

    // ************************************************************
    // register storage
    // ************************************************************
    logic [7:0] out_fmt_reg;    // output mode
    logic [7:0] phase_reg;      // clock phase select
    logic [7:0] oclk_dly_reg;   // output clock delay
    logic [7:0] ref_reg;        // reference range
    logic [7:0] dither_reg;     // dither control
    logic [7:0] sync_reg;       // divider sync control
    logic [7:0] sync_next;      // sync control next value

    // address decode
    wire wr_fmt    = reg_wr && (reg_addr == ADDR_OUT_FMT);
    wire wr_phase  = reg_wr && (reg_addr == ADDR_PHASE);
    wire wr_dly    = reg_wr && (reg_addr == ADDR_OCLK_DLY);
    wire wr_ref    = reg_wr && (reg_addr == ADDR_REF_RANGE);
    wire wr_dither = reg_wr && (reg_addr == ADDR_DITHER);
    wire wr_sync   = reg_wr && (reg_addr == ADDR_SYNC);

    // writable registers, open bits kept zero
    always_ff @(posedge clk) begin
        if (rst) begin
            out_fmt_reg  <= RST_OUT_FMT;
            phase_reg    <= RST_PHASE;
            oclk_dly_reg <= RST_OCLK_DLY;
            ref_reg      <= RST_REF_RANGE;
            dither_reg   <= RST_DITHER;
            sync_reg     <= RST_SYNC;
        end else begin
            if (wr_fmt)    out_fmt_reg  <= reg_wdata & MASK_OUT_FMT;
            if (wr_phase)  phase_reg    <= reg_wdata & MASK_PHASE;
            if (wr_dly)    oclk_dly_reg <= reg_wdata & MASK_OCLK_DLY;
            if (wr_ref)    ref_reg      <= reg_wdata & MASK_REF_RANGE;
            if (wr_dither) dither_reg   <= reg_wdata & MASK_DITHER;
            sync_reg <= sync_next;
        end
    end

    // read mux, unmapped addresses read zero
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr)
            ADDR_OUT_FMT:   rd_mux = out_fmt_reg;
            ADDR_PHASE:     rd_mux = phase_reg;
            ADDR_OCLK_DLY:  rd_mux = oclk_dly_reg;
            ADDR_REF_RANGE: rd_mux = ref_reg;
            ADDR_SIG_LOW:   rd_mux = built_in_self_test_sig[7:0];
            ADDR_SIG_HIGH:  rd_mux = built_in_self_test_sig[15:8];
            ADDR_DITHER:    rd_mux = dither_reg;
            ADDR_SYNC:      rd_mux = sync_reg;
            default:        rd_mux = 8'h00;
        endcase
    end

    // read data captured on read strobe
    always_ff @(posedge clk) begin
        if (rst) reg_rdata <= 8'h00;
        else if (reg_rd) reg_rdata <= rd_mux;
    end

    // ************************************************************
    // sample formatting
    // ************************************************************
    out_format_t fmt;
    assign fmt = out_format_t'(out_fmt_reg[FMT_LSB +: 2]);
    wire [SAMPLE_W-1:0] twos_val = {~sample_in[SAMPLE_W-1], sample_in[SAMPLE_W-2:0]};
    wire [SAMPLE_W-1:0] gray_val = sample_in ^ (sample_in >> 1);
    logic [SAMPLE_W-1:0] fmt_val;
    always_comb begin
        case (fmt)
            FMT_TWOS: fmt_val = twos_val;
            FMT_GRAY: fmt_val = gray_val;
            default:  fmt_val = sample_in;
        endcase
    end
    // output invert flips every data bit
    wire [SAMPLE_W-1:0] inv_mask = {SAMPLE_W{out_fmt_reg[INVERT_BIT]}};

    // registered sample output
    always_ff @(posedge clk) begin
        if (rst) sample_out <= '0;
        else     sample_out <= fmt_val ^ inv_mask;
    end

    // ************************************************************
    // driver, clock and analog controls
    // ************************************************************
    localparam int DLY_PROD_W = 17;  // wide enough for 2500*31
    wire [DLY_PROD_W-1:0] dly_prod = DLY_PROD_W'(OCLK_FULL_PS) * DLY_PROD_W'(oclk_dly_reg[DLY_LSB +: 5]);
    // half a step added so the delay rounds to the nearest picosecond
    wire [DLY_PROD_W-1:0] dly_round = dly_prod + DLY_PROD_W'(OCLK_SPAN / 2);
    wire [DLY_PROD_W-1:0] dly_div   = dly_round / DLY_PROD_W'(OCLK_SPAN);

    // registered control outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            output_is_lvds     <= 1'b0;
            lvds_reduced_drive <= 1'b0;
            outputs_disabled   <= 1'b0;
            data_output_clock  <= 1'b0;
            oclk_delay_code    <= 5'h00;
            oclk_delay_ps      <= 12'h000;
            ref_range_code     <= RST_REF_RANGE[REF_LSB +: 2];
            dither_enable      <= 1'b0;
        end else begin
            output_is_lvds     <= out_fmt_reg[TYPE_BIT];
            lvds_reduced_drive <= out_fmt_reg[TYPE_BIT] & out_fmt_reg[DRIVE_BIT];
            outputs_disabled   <= out_fmt_reg[OE_BAR_BIT];
            data_output_clock  <= data_output_clock_src ^ phase_reg[OCLK_INV_BIT];
            oclk_delay_code    <= oclk_dly_reg[DLY_LSB +: 5];
            oclk_delay_ps      <= dly_div[11:0];
            ref_range_code     <= ref_reg[REF_LSB +: 2];
            dither_enable      <= dither_reg[DITHER_BIT];
        end
    end

    // ************************************************************
    // divider input delay line
    // ************************************************************
    logic [6:0] tick_shift_reg;  // tick history, one stage per cycle
    always_ff @(posedge clk) begin
        if (rst) tick_shift_reg <= 7'h00;
        else     tick_shift_reg <= {tick_shift_reg[5:0], divider_tick_in};
    end
    wire [2:0] phase_code = phase_reg[PHASE_LSB +: 3];
    // code zero passes straight through, otherwise tapped stage
    assign divider_tick_out = (phase_code == 3'h0) ? divider_tick_in
                            : tick_shift_reg[phase_code - 3'h1];

    // ************************************************************
    // sync input and divider alignment
    // ************************************************************
    logic [2:0] sync_sr_reg;   // pin synchroniser chain
    logic       sync_lvl_reg;  // filtered pin level
    always_ff @(posedge clk) begin
        if (rst) begin
            sync_sr_reg  <= 3'h0;
            sync_lvl_reg <= 1'b0;
        end else begin
            sync_sr_reg <= {sync_sr_reg[1:0], sync_pin};
            if (sync_sr_reg[1] == sync_sr_reg[2]) sync_lvl_reg <= sync_sr_reg[2];
        end
    end
    // rising edge of the filtered level
    wire sync_rise = (sync_sr_reg[1] == sync_sr_reg[2]) && sync_sr_reg[2] && !sync_lvl_reg;
    wire master_en = sync_reg[MASTER_BIT];
    wire sync_gate = master_en && sync_reg[DIV_SYNC_BIT];
    wire sync_hit  = sync_gate && sync_rise;
    wire one_shot  = sync_hit && sync_reg[NEXT_ONLY_BIT];

    // sync control next value; a software write wins over self clear
    always_comb begin
        sync_next = sync_reg;
        if (wr_sync) begin
            sync_next = reg_wdata & MASK_SYNC;
        end else if (one_shot) begin
            sync_next[DIV_SYNC_BIT] = 1'b0;
        end
    end

    // registered sync pulse and power enable
    always_ff @(posedge clk) begin
        if (rst) begin
            divider_sync_pulse <= 1'b0;
            sync_power_enable  <= 1'b0;
        end else begin
            divider_sync_pulse <= sync_hit;
            sync_power_enable  <= master_en;
        end
    end

endmodule // adc_output_config_regs
`default_nettype wire

// [hdl/out_cfg_pkg.sv]
// constants for the converter output configuration register bank
// ****************************************************************
// How it works
// - format field picks offset, twos, gray
// - output type bit picks CMOS or LVDS
// - drive bit reduces LVDS current level
// - output clock delay is 2500ps*code/31
// - phase field delays divider input cycles
// - reference field sets full-scale input range
// - no sync action without master enable
// - master plus divider enable passes pulses
// - next-only aligns once, clears divider enable
// ****************************************************************
package out_cfg_pkg;
    // register addresses
    localparam logic [12:0] ADDR_OUT_FMT   = 13'h0014;
    localparam logic [12:0] ADDR_PHASE     = 13'h0016;
    localparam logic [12:0] ADDR_OCLK_DLY  = 13'h0017;
    localparam logic [12:0] ADDR_REF_RANGE = 13'h0018;
    localparam logic [12:0] ADDR_SIG_LOW   = 13'h0024;
    localparam logic [12:0] ADDR_SIG_HIGH  = 13'h0025;
    localparam logic [12:0] ADDR_DITHER    = 13'h0030;
    localparam logic [12:0] ADDR_SYNC      = 13'h0100;
    // reset values
    localparam logic [7:0] RST_OUT_FMT   = 8'h00;
    localparam logic [7:0] RST_PHASE     = 8'h00;
    localparam logic [7:0] RST_OCLK_DLY  = 8'h00;
    localparam logic [7:0] RST_REF_RANGE = 8'hC0;
    localparam logic [7:0] RST_DITHER    = 8'h00;
    localparam logic [7:0] RST_SYNC      = 8'h00;
    // implemented bits; open bits read as zero
    localparam logic [7:0] MASK_OUT_FMT   = 8'hD7;
    localparam logic [7:0] MASK_PHASE     = 8'h87;
    localparam logic [7:0] MASK_OCLK_DLY  = 8'h1F;
    localparam logic [7:0] MASK_REF_RANGE = 8'hC0;
    localparam logic [7:0] MASK_DITHER    = 8'h10;
    localparam logic [7:0] MASK_SYNC      = 8'h07;
    // field positions
    localparam int FMT_LSB       = 0;
    localparam int INVERT_BIT    = 2;
    localparam int OE_BAR_BIT    = 4;
    localparam int TYPE_BIT      = 6;
    localparam int DRIVE_BIT     = 7;
    localparam int PHASE_LSB     = 0;
    localparam int OCLK_INV_BIT  = 7;
    localparam int DLY_LSB       = 0;
    localparam int REF_LSB       = 6;
    localparam int DITHER_BIT    = 4;
    localparam int MASTER_BIT    = 0;
    localparam int DIV_SYNC_BIT  = 1;
    localparam int NEXT_ONLY_BIT = 2;
    // output format codes
    typedef enum logic [1:0] {
        FMT_OFFSET_BIN = 2'b00,
        FMT_TWOS       = 2'b01,
        FMT_GRAY       = 2'b10,
        FMT_OFFSET_ALT = 2'b11
    } out_format_t;
    // delay scale: full-scale delay and code span
    localparam int OCLK_FULL_PS = 2500;
    localparam int OCLK_SPAN    = 31;
endpackage

// [tb/adc_output_config_regs_asserts.sv]
// timing checks on the output configuration register bank ports
`timescale 1ns/100ps
`default_nettype none
module adc_output_config_regs_asserts
    import out_cfg_pkg::*;
(
    // clock, reset, write port
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        reg_wr,
    input wire logic [12:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    // watched outputs
    input wire logic        output_is_lvds,
    input wire logic        lvds_reduced_drive,
    input wire logic [4:0]  oclk_delay_code,
    input wire logic [11:0] oclk_delay_ps,
    input wire logic [1:0]  ref_range_code,
    input wire logic        data_output_clock_src,
    input wire logic        data_output_clock,
    input wire logic        sync_pin,
    input wire logic        sync_power_enable,
    input wire logic        divider_sync_pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // a write to one place, two edges on to the outputs
    sequence s_wr(a);
        reg_wr && reg_addr == a ##2 1'b1;
    endsequence
    property p_lvds; s_wr(ADDR_OUT_FMT) |-> output_is_lvds == $past(reg_wdata[6], 2); endproperty
    a_lvds: assert property (p_lvds) else $error("output type wrong");
    property p_drive; s_wr(ADDR_OUT_FMT) |-> lvds_reduced_drive == &$past(reg_wdata[7:6], 2); endproperty
    a_drive: assert property (p_drive) else $error("drive level wrong");
    property p_dly; s_wr(ADDR_OCLK_DLY) |-> oclk_delay_code == $past(reg_wdata[4:0], 2)
        && oclk_delay_ps == 12'((OCLK_FULL_PS * oclk_delay_code + OCLK_SPAN / 2) / OCLK_SPAN); endproperty
    a_dly: assert property (p_dly) else $error("clock delay wrong");
    property p_ref; s_wr(ADDR_REF_RANGE) |-> ref_range_code == $past(reg_wdata[7:6], 2); endproperty
    a_ref: assert property (p_ref) else $error("range code wrong");
    property p_inv; s_wr(ADDR_PHASE) |-> data_output_clock == ($past(data_output_clock_src) ^ $past(reg_wdata[7], 2));
    endproperty
    a_inv: assert property (p_inv) else $error("clock polarity wrong");
    property p_master; s_wr(ADDR_SYNC) |-> sync_power_enable == $past(reg_wdata[0], 2); endproperty
    a_master: assert property (p_master) else $error("master enable wrong");
    property p_gate; divider_sync_pulse |-> sync_power_enable && $past(sync_pin, 3); endproperty
    a_gate: assert property (p_gate) else $error("stray divider pulse");
    property p_pulse; divider_sync_pulse |=> !divider_sync_pulse; endproperty
    a_pulse: assert property (p_pulse) else $error("divider pulse too long");
    property p_rst; disable iff (1'b0) rst |=> ref_range_code == 2'b11 && !output_is_lvds; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    c_sync: cover property (divider_sync_pulse);
endmodule // adc_output_config_regs_asserts
bind adc_output_config_regs adc_output_config_regs_asserts chk_u (.clk, .rst, .reg_wr, .reg_addr, .reg_wdata,
    .output_is_lvds, .lvds_reduced_drive, .oclk_delay_code, .oclk_delay_ps, .ref_range_code,
    .data_output_clock_src, .data_output_clock, .sync_pin, .sync_power_enable, .divider_sync_pulse);
`default_nettype wire

// [tb/adc_output_config_regs_bench.sv]
// self-checking bench for the output configuration register bank
`timescale 1ns/100ps
`default_nettype none
module adc_output_config_regs_bench;
    import out_cfg_pkg::*;
    logic clk = 1'b0, rst = 1'b1, reg_wr, reg_rd, divider_tick_in = 1'b0, divider_tick_out, sync_pin = 1'b0;
    logic output_is_lvds, lvds_reduced_drive, data_output_clock, divider_sync_pulse;
    logic oclk_src = 1'b0, outputs_disabled, dither_enable, sync_power_enable;
    logic [1:0]  ref_range_code;
    logic [12:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, d, cfg;
    logic [15:0] sample_in = 16'h0000, sample_out, b, e;
    logic [4:0]  oclk_delay_code;
    logic [11:0] oclk_delay_ps;
    int err_count = 0, samples_checked = 0, cycles = 0, pulses = 0, base, i, n;
    logic [12:0] a_tab [8] = '{ADDR_OUT_FMT, ADDR_PHASE, ADDR_OCLK_DLY, ADDR_REF_RANGE,
                               ADDR_SIG_LOW, ADDR_SIG_HIGH, ADDR_DITHER, ADDR_SYNC};
    logic [7:0]  r_tab [8] = '{RST_OUT_FMT, RST_PHASE, RST_OCLK_DLY, RST_REF_RANGE, 8'h5A, 8'hA5, RST_DITHER, RST_SYNC};
    logic [7:0]  m_tab [8] = '{MASK_OUT_FMT, MASK_PHASE, MASK_OCLK_DLY, MASK_REF_RANGE, 8'h5A, 8'hA5, MASK_DITHER, MASK_SYNC};
    logic [7:0]  s_tab [3] = '{8'h02, 8'h03, 8'h07};
    logic [7:0]  s_back [3] = '{8'h02, 8'h03, 8'h05};
    int          s_cnt [3] = '{0, 2, 1};
    int          ps_tab [3] = '{81, 2419, 2500};
    logic [4:0]  o_tab [8] = '{5'h16, 5'h06, 5'h06, 5'h06, 5'h06, 5'h06, 5'h0E, 5'h07};
    always #2 clk = ~clk;
    // host and device
    host_model host_u (.clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
    adc_output_config_regs dut_u (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .sample_in,
        .sample_out, .output_is_lvds, .lvds_reduced_drive, .outputs_disabled, .data_output_clock_src(oclk_src),
        .data_output_clock, .oclk_delay_code, .oclk_delay_ps, .divider_tick_in, .divider_tick_out,
        .ref_range_code, .dither_enable, .built_in_self_test_sig(16'hA55A), .sync_pin,
        .sync_power_enable, .divider_sync_pulse);
    // count divider pulses, cut a hang short
    always @(posedge clk) begin
        pulses <= pulses + int'(divider_sync_pulse);
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checked %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // sync pin high then low, both held well past the filter
    task automatic sync_rise();
        @(posedge clk) sync_pin <= 1'b1;
        repeat (6) @(posedge clk);
        sync_pin <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        // reset values, then all ones through masks and read-only places
        for (i = 0; i < 8; i++) begin
            host_u.rd(a_tab[i], d);
            check(16'(d), 16'(r_tab[i]));
            host_u.wr(a_tab[i], 8'hFF);
            host_u.rd(a_tab[i], d);
            check(16'(d), 16'(m_tab[i]));
            check(16'({outputs_disabled, dither_enable, ref_range_code, sync_power_enable}), 16'(o_tab[i]));
            host_u.wr(a_tab[i], r_tab[i]);
        end
        host_u.rd(13'h0020, d);
        check(16'(d), 16'h0000);
        // every format with and without invert, output type and drive
        for (i = 0; i < 8; i++) begin
            cfg = {i[2], i[0], 3'b000, i[2], i[1:0]};
            host_u.wr(ADDR_OUT_FMT, cfg);
            sample_in <= 16'h9C35 + 16'(i);
            repeat (3) @(posedge clk);
            #1 b = sample_in;
            e = (cfg[1:0] == 2'b01) ? b ^ 16'h8000 : (cfg[1:0] == 2'b10) ? b ^ (b >> 1) : b;
            check(sample_out, e ^ {16{cfg[2]}});
            check(16'(output_is_lvds), 16'(cfg[6]));
            check(16'(lvds_reduced_drive), 16'(cfg[6] & cfg[7]));
        end
        // phase code 3 with clock invert
        host_u.wr(ADDR_PHASE, 8'h83);
        @(posedge clk) divider_tick_in <= 1'b1;
        @(posedge clk) divider_tick_in <= 1'b0;
        n = 1;
        #1;
        while (divider_tick_out !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1 n++;
        end
        check(16'(n), 16'h0003);
        check(16'(data_output_clock), 16'h0001);
        // source high with invert gives low, invert off gives high
        @(posedge clk) oclk_src <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check(16'(data_output_clock), 16'h0000);
        host_u.wr(ADDR_PHASE, 8'h00);
        repeat (2) @(posedge clk);
        #1 check(16'(data_output_clock), 16'h0001);
        // phase code zero passes the tick straight through
        @(posedge clk) divider_tick_in <= 1'b1;
        #1 check(16'(divider_tick_out), 16'h0001);
        @(posedge clk) divider_tick_in <= 1'b0;
        // delay codes at both ends of the span
        for (i = 0; i < 3; i++) begin
            cfg = (i == 0) ? 8'h01 : 8'(29 + i);
            host_u.wr(ADDR_OCLK_DLY, cfg);
            repeat (2) @(posedge clk);
            #1 check(16'(oclk_delay_ps), 16'(ps_tab[i]));
        end
        // a reference code other than the reset choice
        host_u.wr(ADDR_REF_RANGE, 8'h40);
        repeat (2) @(posedge clk);
        #1 check(16'(ref_range_code), 16'h0001);
        // sync off, continuous, next-only with self-clear
        for (i = 0; i < 3; i++) begin
            host_u.wr(ADDR_SYNC, s_tab[i]);
            base = pulses;
            repeat (2) sync_rise();
            host_u.rd(ADDR_SYNC, d);
            check(16'(d), 16'(s_back[i]));
            check(16'(pulses - base), 16'(s_cnt[i]));
        end
        report_and_stop();
    end
endmodule // adc_output_config_regs_bench
`default_nettype wire

// [tb/host_model.sv]
// serial core side model that issues register writes and reads
`timescale 1ns/100ps
`default_nettype none
module host_model (
    // clock and read data
    input  wire logic        clk,
    input  wire logic [7:0]  reg_rdata,
    // request lines
    output var  logic        reg_wr,
    output var  logic        reg_rd,
    output var  logic [12:0] reg_addr,
    output var  logic [7:0]  reg_wdata
);
    // idle port from time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 13'h0000;
        reg_wdata = 8'h00;
    end
    // one write strobe, then released
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk) reg_wr <= 1'b0;
    endtask
    // one read strobe, data taken the edge after
    task automatic rd(input logic [12:0] a, output logic [7:0] d);
        @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk) reg_rd <= 1'b0;
        @(posedge clk) d = reg_rdata;
    endtask
endmodule // host_model
`default_nettype wire
